// file: rtl/tmz_pkg.sv
// Shared constants for the 8-bit timer with shared prescaler
package tmz_pkg;

    // ************************************************************
    // Register map and widths
    // ************************************************************
    localparam int unsigned ADDR_W       = 2;
    localparam int unsigned DATA_W       = 8;
    localparam logic [1:0]  OFS_COUNT    = 2'h0;
    localparam logic [1:0]  OFS_OPTION   = 2'h1;
    localparam logic [1:0]  OFS_INTCTL   = 2'h2;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned OPT_CSEL     = 5;   // Clock source select
    localparam int unsigned OPT_ESEL     = 4;   // Source edge select
    localparam int unsigned OPT_ASSIGN   = 3;   // Prescaler assignment
    localparam int unsigned OPT_RATE_LO  = 0;   // Prescale rate, 3 bits
    localparam int unsigned INT_EN       = 5;   // Overflow interrupt enable
    localparam int unsigned INT_FLAG     = 2;   // Overflow flag

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_COUNT    = 8'h00;
    localparam logic [7:0]  RST_OPTION   = 8'hFF;
    localparam logic [7:0]  RST_MAX      = 8'hFF;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PER_INSTR = 4;  // Clocks per instruction cycle
    localparam logic [1:0]  PH_Q2         = 2'h1;
    localparam logic [1:0]  PH_Q4         = 2'h3;
    localparam logic [1:0]  INHIBIT_INSTR = 2'h2;

endpackage : tmz_pkg

// file: rtl/tmz_edge.sv
// Selected-edge detector for the external count input
`timescale 1ns/100ps
module tmz_edge (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic NRST,
    // Pin and selection
    input  wire logic pin,
    input  wire logic fall_sel,
    // Detected edge
    output logic      pulse
);

    logic prev;

    // ************************************************************
    // Edge capture
    // ************************************************************

    // Previous pin level
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            prev <= 1'b0;
        end else begin
            prev <= pin;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pulse <= 1'b0;
        end else begin
            pulse <= fall_sel ? (prev & ~pin) : (~prev & pin);
        end
    end

    AST_EDGE_POL: assert property (@(posedge CLK) disable iff (!NRST)
        (fall_sel && prev && !pin) |=> pulse)
        else $error("Selected falling edge not detected");

endmodule : tmz_edge

// file: rtl/tmz_prescaler.sv
// Shared binary prescaler with selectable tap
`timescale 1ns/100ps
module tmz_prescaler #(
    parameter int unsigned STAGES = 8
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       NRST,
    // Control
    input  wire logic       clr,
    input  wire logic       evt,
    input  wire logic [2:0] rate,
    // Divided event
    output logic            tick
);

    logic [STAGES-1:0] cnt;

    initial begin
        if (STAGES != 8) $error("tmz_prescaler serves eight stages only");
    end

    // Low bits that must be all ones for the chosen ratio
    function automatic logic [STAGES-1:0] tap_mask(input logic [2:0] r);
        tap_mask = STAGES'((9'h002 << r) - 9'h001);
    endfunction : tap_mask

    // ************************************************************
    // Counter
    // ************************************************************

    always_ff @(posedge CLK) begin
        if (!NRST || clr) begin
            cnt <= '0;
        end else if (evt) begin
            cnt <= cnt + 1'b1;
        end
    end

    // ratio two to the rate plus one
    assign tick = evt && !clr && ((cnt & tap_mask(rate)) == tap_mask(rate));

    AST_PRE_CLR: assert property (@(posedge CLK) disable iff (!NRST)
        clr |=> (cnt == '0))
        else $error("Prescaler not cleared");

    // divide by two at rate zero
    AST_PRE_DIV2: assert property (@(posedge CLK) disable iff (!NRST)
        (rate == 3'h0 && evt && !clr && !cnt[0]) |-> !tick)
        else $error("Prescaler ticked on even event");

endmodule : tmz_prescaler

// file: rtl/tmz_timer.sv
// 8-bit timer/counter with prescaler shared with the watchdog
`timescale 1ns/100ps

module tmz_timer #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          NRST,
    // Register port
    input  wire logic [tmz_pkg::ADDR_W-1:0]    ADDR,
    input  wire logic [tmz_pkg::DATA_W-1:0]    WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [tmz_pkg::DATA_W-1:0]    RDATA,
    // External count input and core state
    input  wire logic                          COUNT_INPUT_PIN,
    input  wire logic                          SLEEP,
    // Watchdog side of the shared prescaler
    input  wire logic                          WATCHDOG_TICK,
    input  wire logic                          WATCHDOG_CLEAR_INSTRUCTION,
    output logic                               WATCHDOG_PRESCALED,
    // Interrupt request
    output logic                               TIMER_INT
);

    logic [WIDTH-1:0] count_reg;
    logic [7:0]       option_reg;
    logic             overflow_flag;
    logic             overflow_int_enable;
    logic [1:0]       phase;
    logic [1:0]       inhibit;
    logic             pending;
    logic             edge_pulse;
    logic             pre_tick;
    logic             q2;
    logic             q4;
    logic             wr_count;
    logic             wr_intctl;
    logic             clock_source_select;
    logic             prescaler_assign;
    logic             src_evt;
    logic             div_evt;
    logic             inc_req;
    logic             inc_ok;
    logic             wrap;

    initial begin
        if (WIDTH != 8) $error("tmz_timer supports an 8-bit count only");
    end

    // ************************************************************
    // Decode and option fields
    // ************************************************************

    // Register write selects
    assign wr_count  = WR && (ADDR == tmz_pkg::OFS_COUNT);
    assign wr_intctl = WR && (ADDR == tmz_pkg::OFS_INTCTL);

    assign prescaler_assign    = option_reg[tmz_pkg::OPT_ASSIGN];
    assign clock_source_select = option_reg[tmz_pkg::OPT_CSEL];

    // Instruction-cycle phases
    assign q2 = (phase == tmz_pkg::PH_Q2);
    assign q4 = (phase == tmz_pkg::PH_Q4);

    // ************************************************************
    // Instruction-cycle phase counter
    // ************************************************************

    // Four clocks per instruction cycle
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // ************************************************************
    // Event sources and prescaler
    // ************************************************************

    tmz_edge u_edge (
        .CLK      (CLK),
        .NRST     (NRST),
        .pin      (COUNT_INPUT_PIN),
        .fall_sel (option_reg[tmz_pkg::OPT_ESEL]),
        .pulse    (edge_pulse)
    );

    assign src_evt = clock_source_select ? edge_pulse : q4;

    // count write clears it for the timer
    // watchdog clear clears it for the watchdog
    tmz_prescaler #(
        .STAGES (8)
    ) u_pre (
        .CLK  (CLK),
        .NRST (NRST),
        .clr  (prescaler_assign ? WATCHDOG_CLEAR_INSTRUCTION : wr_count),
        .evt  (prescaler_assign ? WATCHDOG_TICK : src_evt),
        .rate (option_reg[tmz_pkg::OPT_RATE_LO +: 3]),
        .tick (pre_tick)
    );

    assign div_evt = prescaler_assign ? src_evt : pre_tick;

    // Prescaled watchdog tick
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            WATCHDOG_PRESCALED <= 1'b0;
        end else begin
            WATCHDOG_PRESCALED <= prescaler_assign && pre_tick;
        end
    end

    // ************************************************************
    // Counter-mode synchroniser
    // ************************************************************

    // hold divided edge until Q2 or Q4
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pending <= 1'b0;
        end else if (!clock_source_select || (q2 || q4)) begin
            pending <= 1'b0;
        end else if (div_evt) begin
            pending <= 1'b1;
        end
    end

    // Increment request for either mode
    assign inc_req = clock_source_select ? ((q2 || q4) && (pending || div_evt)) : div_evt;

    assign inc_ok = inc_req && (inhibit == 2'h0) && !SLEEP && !wr_count;
    assign wrap   = inc_ok && (count_reg == tmz_pkg::RST_MAX);

    // ************************************************************
    // Write inhibit
    // ************************************************************

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            inhibit <= 2'h0;
        end else if (wr_count) begin
            inhibit <= tmz_pkg::INHIBIT_INSTR;
        end else if (q4 && (inhibit != 2'h0)) begin
            inhibit <= inhibit - 2'h1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            count_reg <= tmz_pkg::RST_COUNT;
        end else if (wr_count) begin
            count_reg <= WDATA;
        end else if (inc_ok) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Option register
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            option_reg <= tmz_pkg::RST_OPTION;
        end else if (WR && (ADDR == tmz_pkg::OFS_OPTION)) begin
            option_reg <= WDATA;
        end
    end

    // set on wrap, set beats clear
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (wr_intctl) begin
            overflow_flag <= WDATA[tmz_pkg::INT_FLAG];
        end
    end

    // Interrupt enable bit
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            overflow_int_enable <= 1'b0;
        end else if (wr_intctl) begin
            overflow_int_enable <= WDATA[tmz_pkg::INT_EN];
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            TIMER_INT <= 1'b0;
        end else begin
            TIMER_INT <= overflow_int_enable && overflow_flag;
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= '0;
        end else if (RD) begin
            case (ADDR)
                tmz_pkg::OFS_COUNT:  RDATA <= count_reg;
                tmz_pkg::OFS_OPTION: RDATA <= option_reg;
                tmz_pkg::OFS_INTCTL: begin
                    RDATA                    <= '0;
                    RDATA[tmz_pkg::INT_EN]   <= overflow_int_enable;
                    RDATA[tmz_pkg::INT_FLAG] <= overflow_flag;
                end
                default:             RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_timer_write;
        wr_count && !clock_source_select;
    endsequence

    sequence s_quiet_7;
        (!WR)[*7];
    endsequence

    AST_WRITE_LOAD: assert property (wr_count |=> count_reg == $past(WDATA))
        else $error("Count write not loaded");

    AST_WRITE_STALL: assert property (s_timer_write ##1 s_quiet_7 |-> count_reg == $past(count_reg, 6))
        else $error("Count moved during write stall");

    AST_TIMER_STEP: assert property ((q4 && !clock_source_select && prescaler_assign && inhibit == 2'h0
        && !SLEEP && !WR) |=> count_reg == $past(count_reg) + 1'b1)
        else $error("Timer missed instruction cycle");

    AST_OVF_SET: assert property (wrap |=> overflow_flag)
        else $error("Wrap did not set flag");

    AST_INT_GATE: assert property (##1 TIMER_INT == $past(overflow_int_enable && overflow_flag))
        else $error("Interrupt not gated by enable and flag");

    AST_SLEEP_HOLD: assert property ((SLEEP && !WR) |=> $stable(count_reg))
        else $error("Count moved during sleep");

    AST_CNT_SYNC: assert property ((clock_source_select && !q2 && !q4 && !WR) |=> $stable(count_reg))
        else $error("Counter mode increment off Q2 or Q4");

    AST_READ_COUNT: assert property ((RD && ADDR == tmz_pkg::OFS_COUNT) |=> RDATA == $past(count_reg))
        else $error("Count read back wrong");

    AST_RDATA_IDLE: assert property (!RD |=> RDATA == '0)
        else $error("Read data not zero without read strobe");

    AST_FLAG_KEEP: assert property ((overflow_flag && !wr_intctl) |=> overflow_flag)
        else $error("Overflow flag cleared without software write");

    AST_WD_OWNER: assert property (!prescaler_assign |=> !WATCHDOG_PRESCALED)
        else $error("Watchdog tick while prescaler serves the timer");

endmodule : tmz_timer

// file: verif/tmz_src.sv
// Model of the external event source on the count pin
`timescale 1ns/100ps
module tmz_src (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Request from the bench
    input  wire logic       start,
    input  wire logic [7:0] toggles,
    input  wire logic [3:0] half,
    // Pin side
    output logic            pin,
    output logic            busy
);
    logic [7:0] left;
    logic [3:0] cnt;

    // toggle pin, each level held half+1 cycles
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin <= 1'b0;
            left <= 8'h00;
            cnt <= 4'h0;
        end else if (start) begin
            left <= toggles;
            cnt <= half;
        end else if (left != 8'h00) begin
            if (cnt == 4'h0) begin
                pin <= ~pin;
                left <= left - 8'h01;
                cnt <= half;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end

    // Busy while toggles remain
    assign busy = start || (left != 8'h00);
endmodule : tmz_src

// file: verif/tb_tmz_timer.sv
// Self-checking testbench for the 8-bit timer with shared prescaler
`timescale 1ns/100ps
module tb_tmz_timer;
    logic       clk;
    logic       nrst;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       pin;
    logic       sleep;
    logic       wd_tick;
    logic       wd_clr;
    logic       wd_out;
    logic       timer_int;
    logic       start;
    logic [7:0] toggles;
    logic       busy;
    int         errors;
    int         checks;
    int         wd_cnt;
    int         base;
    int         i;
    logic [7:0] got;
    logic [7:0] row_opt [0:12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                   8'h07, 8'h08, 8'h28, 8'h38, 8'h20, 8'h31};
    logic [7:0] row_n   [0:12] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04,
                                   8'h04, 8'h04, 8'h07, 8'h07, 8'h08, 8'h09};

    tmz_timer tmz_timer_i (
        .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .COUNT_INPUT_PIN(pin), .SLEEP(sleep), .WATCHDOG_TICK(wd_tick),
        .WATCHDOG_CLEAR_INSTRUCTION(wd_clr), .WATCHDOG_PRESCALED(wd_out), .TIMER_INT(timer_int)
    );

    tmz_src tmz_src_i (
        .clk(clk), .nrst(nrst), .start(start), .toggles(toggles), .half(4'h7),
        .pin(pin), .busy(busy)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Count divided watchdog pulses
    always @(posedge clk) begin
        if (wd_out === 1'b1) begin
            wd_cnt++;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic chk_rng(input string what, input logic [7:0] lo, input logic [7:0] hi,
                           input logic [7:0] seen);
        checks++;
        if ((seen >= lo && seen <= hi) !== 1'b1) begin
            errors++;
            $display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, seen);
        end
    endtask : chk_rng

    task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : bus_rd

    task automatic pulse_wd(input bit clr);
        @(posedge clk);
        if (clr) wd_clr <= 1'b1;
        else wd_tick <= 1'b1;
        @(posedge clk);
        wd_clr <= 1'b0;
        wd_tick <= 1'b0;
    endtask : pulse_wd

    task automatic end_test(input string name);
        $display("test %s done, checks %0d errors %0d", name, checks, errors);
    endtask : end_test

    task automatic check_reset();
        bus_rd(tmz_pkg::OFS_COUNT, got);
        chk("count", tmz_pkg::RST_COUNT, got);
        bus_rd(tmz_pkg::OFS_OPTION, got);
        chk("option", tmz_pkg::RST_OPTION, got);
        bus_rd(tmz_pkg::OFS_INTCTL, got);
        chk("intctl", 8'h00, got);
        chk("int", 8'h00, {7'h00, timer_int});
    endtask : check_reset

    // One row: program option, load count, run events, read back
    task automatic run_row(input logic [7:0] opt, input logic [7:0] n);
        int ratio;
        int ev;
        int k;
        ratio = opt[3] ? 1 : (2 << opt[2:0]);
        // clear count and prescaler before moving the assignment
        bus_wr(tmz_pkg::OFS_COUNT, 8'h00);
        pulse_wd(1'b1);
        bus_wr(tmz_pkg::OFS_OPTION, opt);
        bus_wr(tmz_pkg::OFS_COUNT, 8'h10);
        if (!opt[5]) begin
            repeat (4 * (2 + ratio * n)) @(posedge clk);
            ev = n * ratio;
        end else begin
            repeat (12) @(posedge clk);
            ev = (opt[4] == pin) ? (n + 1) / 2 : n / 2;
            toggles <= n;
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk);
            if (k == 400) begin
                errors++;
                print_verdict();
            end
            repeat (16) @(posedge clk);
        end
        bus_rd(tmz_pkg::OFS_COUNT, got);
        chk_rng("count row", 8'(16 + ev / ratio - !opt[5]), 8'(16 + ev / ratio + !opt[5]), got);
    endtask : run_row

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        sleep = 1'b0;
        wd_tick = 1'b0;
        wd_clr = 1'b0;
        start = 1'b0;
        toggles = 8'h00;
        errors = 0;
        checks = 0;
        wd_cnt = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        check_reset();
        bus_wr(2'h3, 8'hA5);
        bus_rd(2'h3, got);
        chk("unmapped", 8'h00, got);
        @(negedge clk);
        chk("rdata idle", 8'h00, rdata);
        end_test("reset");
        for (i = 0; i < 13; i++) begin
            run_row(row_opt[i], row_n[i]);
        end
        end_test("rows");
        // value written without offset, stall seen as held count
        bus_wr(tmz_pkg::OFS_OPTION, 8'h08);
        bus_wr(tmz_pkg::OFS_COUNT, 8'h40);
        repeat (3) @(posedge clk);
        bus_rd(tmz_pkg::OFS_COUNT, got);
        chk("stall", 8'h40, got);
        repeat (20) @(posedge clk);
        bus_rd(tmz_pkg::OFS_COUNT, got);
        chk_rng("after stall", 8'h44, 8'h45, got);
        end_test("stall");
        bus_wr(tmz_pkg::OFS_INTCTL, 8'h00);
        bus_wr(tmz_pkg::OFS_COUNT, 8'hFE);
        repeat (18) @(posedge clk);
        bus_rd(tmz_pkg::OFS_INTCTL, got);
        chk("flag", 8'h04, got);
        chk("int off", 8'h00, {7'h00, timer_int});
        bus_wr(tmz_pkg::OFS_INTCTL, 8'hFF);
        bus_rd(tmz_pkg::OFS_INTCTL, got);
        chk("intctl bits", 8'h24, got);
        chk("int on", 8'h01, {7'h00, timer_int});
        bus_wr(tmz_pkg::OFS_INTCTL, 8'h20);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("int clear", 8'h00, {7'h00, timer_int});
        end_test("overflow");
        @(posedge clk);
        sleep <= 1'b1;
        bus_wr(tmz_pkg::OFS_COUNT, 8'h55);
        repeat (40) @(posedge clk);
        bus_rd(tmz_pkg::OFS_COUNT, got);
        chk("sleep", 8'h55, got);
        @(posedge clk);
        sleep <= 1'b0;
        repeat (40) @(posedge clk);
        bus_rd(tmz_pkg::OFS_COUNT, got);
        chk_rng("wake", 8'h5F, 8'h60, got);
        end_test("sleep");
        bus_wr(tmz_pkg::OFS_OPTION, 8'h09);
        pulse_wd(1'b1);
        base = wd_cnt;
        repeat (3) pulse_wd(1'b0);
        pulse_wd(1'b1);
        repeat (3) pulse_wd(1'b0);
        repeat (4) @(posedge clk);
        chk("wd cleared", 8'h00, 8'(wd_cnt - base));
        pulse_wd(1'b0);
        repeat (4) @(posedge clk);
        chk("wd divided", 8'h01, 8'(wd_cnt - base));
        end_test("watchdog");
        bus_wr(tmz_pkg::OFS_INTCTL, 8'h24);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        check_reset();
        end_test("second reset");
        print_verdict();
    end
endmodule : tb_tmz_timer
